/* File: src/ld_diag_map.vh */
`ifndef LD_DIAG_MAP_VH
`define LD_DIAG_MAP_VH
// ==============================
// clock and time base
`define LD_CLK_HZ      200000000
`define LD_MS_PER_S    1000
// ==============================
// register byte offsets
`define LD_OFS_CTRL    8'h00
`define LD_OFS_STATUS  8'h04
`define LD_OFS_EXPIN   8'h08
`define LD_OFS_EXPOUT  8'h0c
`define LD_OFS_REMOTE  8'h10
`define LD_OFS_BASEIN  8'h14
// ==============================
// control fields and reset value
`define LD_CTRL_EXP_USED  0
`define LD_CTRL_EXP_REM   1
`define LD_CTRL_DEB_EN    2
`define LD_CTRL_LINK_EN   3
`define LD_CTRL_BAUD_LO   4
`define LD_CTRL_BAUD_HI   5
`define LD_CTRL_RST       6'h04
// ==============================
// status fields
`define LD_ST_BASE_FLT  0
`define LD_ST_EXP_LOW   1
`define LD_ST_EXP_UP    2
`define LD_ST_EXP_DOWN  3
`define LD_ST_PEER_FLT  4
`define LD_ST_SER_BUSY  5
// ==============================
// times in ms
`define LD_EXP_IN_LOC_MS   12'd30
`define LD_EXP_OUT_LOC_MS  12'd15
`define LD_EXP_IN_REM_MS   12'd80
`define LD_EXP_OUT_REM_MS  12'd40
`define LD_SER_TO_96_MS    12'd4000
`define LD_SER_TO_192_MS   12'd3200
`define LD_SER_TO_384_MS   12'd2400
`define LD_SER_TO_576_MS   12'd2000
`define LD_CRC_TO_96_MS    12'd250
`define LD_CRC_TO_192_MS   12'd120
`define LD_NR_TO_96_MS     12'd1500
`define LD_NR_TO_192_MS    12'd800
`define LD_DEB_MS          12'd20
`endif

/* File: src/ld_diag.v */
`timescale 1ns/1ps
`include "ld_diag_map.vh"
// How it works
// RULE_01 - base group fault when any output faulty
// RULE_02 - two expansion group faults, lower and upper
// RULE_03 - expansion counted connected when program uses it
// RULE_04 - expansion data moves both ways over link
// RULE_05 - twelve expansion inputs, eight expansion outputs
// RULE_06 - debounce affects base inputs only
// RULE_07 - local latency 30/15 ms plus cycle
// RULE_08 - remote latency 80/40 ms plus cycle
// RULE_09 - link absent: expansion inputs, faults read zero
// RULE_10 - health flag one while expansion not functional
// RULE_11 - skipped program keeps outputs, never clears
// RULE_12 - serial timeout depends on baud rate
// RULE_13 - stalled exchange dropped, wait for start
// RULE_14 - peer fault bit: zero ok, one faulty
// RULE_15 - crc fault flagged after 250/120 ms
// RULE_16 - no response flagged after 1500/800 ms
// RULE_17 - on fault drop data, clear remote operands
// RULE_18 - after fault, retry a new exchange
// RULE_19 - program should check fault bit, ignore data
// RULE_20 - serial timer restarts per character, clears on telegram
module ld_diag #(
	parameter MS_CYCLES = `LD_CLK_HZ / `LD_MS_PER_S
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// pins from base and expansion (asynchronous)
	input  wire [3:0]  base_out_flt,
	input  wire [3:0]  base_in,
	input  wire        exp_link_up,
	input  wire [1:0]  exp_flt,
	input  wire [11:0] exp_in,
	// program scan and serial telegram events (same clock)
	input  wire        scan_tick,
	input  wire        ser_rx_start,
	input  wire        ser_rx_char,
	input  wire        ser_rx_done,
	input  wire        peer_resp,
	input  wire        peer_crc_err,
	input  wire [15:0] peer_rd_data,
	// flags and link outputs
	output reg         base_output_group_fault,
	output reg         exp_fault_outputs_upper,
	output reg         exp_fault_outputs_lower,
	output reg         expansion_down_flag,
	output reg         peer_link_fault_bit,
	output reg  [11:0] expansion_input_contacts,
	output reg  [7:0]  expansion_output_relays,
	output reg         ser_drop,
	output reg         peer_retry
);

	// ==============================
	// pin synchronisers
	reg  [22:0] sync1_r;
	reg  [22:0] sync2_r;
	wire [22:0] pins = {base_out_flt, base_in, exp_link_up, exp_flt, exp_in};
	wire [3:0]  s_bflt = sync2_r[22:19];
	wire [3:0]  s_bin  = sync2_r[18:15];
	wire        s_up   = sync2_r[14];
	wire [1:0]  s_eflt = sync2_r[13:12];
	wire [11:0] s_ein  = sync2_r[11:0];

	// two stages before any logic
	always @(posedge clk_sys) begin
		if (rst) begin
			sync1_r <= 23'h0;
			sync2_r <= 23'h0;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
		end
	end

	// ==============================
	// millisecond enable
	reg  [31:0] div_r;
	reg         ms_r;

	// one-cycle pulse each ms
	always @(posedge clk_sys) begin
		if (rst) begin
			div_r <= 32'h0;
			ms_r  <= 1'b0;
		end else if (div_r == MS_CYCLES - 1) begin
			div_r <= 32'h0;
			ms_r  <= 1'b1;
		end else begin
			div_r <= div_r + 32'h1;
			ms_r  <= 1'b0;
		end
	end

	// ==============================
	// control register and decode
	reg  [5:0]  ctrl_r;
	reg  [7:0]  exp_out_r;
	reg  [15:0] remote_r;
	reg  [3:0]  base_clean_r;
	reg         ser_busy_r;
	wire        exp_used = ctrl_r[`LD_CTRL_EXP_USED];
	wire        exp_rem  = ctrl_r[`LD_CTRL_EXP_REM];
	wire        deb_en   = ctrl_r[`LD_CTRL_DEB_EN];
	wire        link_en  = ctrl_r[`LD_CTRL_LINK_EN];
	wire [1:0]  baud     = ctrl_r[`LD_CTRL_BAUD_HI:`LD_CTRL_BAUD_LO];
	wire        wr_acc   = psel & penable & pready & pwrite;
	wire        exp_down = exp_used & ~s_up;
	reg  [31:0] rd_mux;
	reg         rd_ok;
	reg  [31:0] status_word;

	// status word, one bit per flag
	always @* begin
		status_word                  = 32'h0;
		status_word[`LD_ST_BASE_FLT] = base_output_group_fault;
		status_word[`LD_ST_EXP_LOW]  = exp_fault_outputs_lower;
		status_word[`LD_ST_EXP_UP]   = exp_fault_outputs_upper;
		status_word[`LD_ST_EXP_DOWN] = expansion_down_flag;
		status_word[`LD_ST_PEER_FLT] = peer_link_fault_bit;
		status_word[`LD_ST_SER_BUSY] = ser_busy_r;
	end

	// read data mux
	always @* begin
		rd_mux = 32'h0;
		rd_ok  = 1'b1;
		case (paddr)
			`LD_OFS_CTRL:   rd_mux = {26'h0, ctrl_r};
			`LD_OFS_STATUS: rd_mux = status_word;
			`LD_OFS_EXPIN:  rd_mux = {20'h0, expansion_input_contacts};
			`LD_OFS_EXPOUT: rd_mux = {24'h0, exp_out_r};
			`LD_OFS_REMOTE: rd_mux = {16'h0, remote_r};
			`LD_OFS_BASEIN: rd_mux = {28'h0, base_clean_r};
			default:        rd_ok  = 1'b0;
		endcase
	end

	// apb: ready in first access cycle, data latched in setup
	always @(posedge clk_sys) begin
		if (rst) begin
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= 32'h0;
			ctrl_r    <= `LD_CTRL_RST;
			exp_out_r <= 8'h0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~rd_ok;
			if (psel & ~penable) begin
				prdata <= pwrite ? 32'h0 : rd_mux;
			end
			if (wr_acc && paddr == `LD_OFS_CTRL) begin
				ctrl_r <= pwdata[5:0];
			end
			if (wr_acc && paddr == `LD_OFS_EXPOUT) begin
				exp_out_r <= pwdata[7:0]; // RULE_05
			end
		end
	end

	// ==============================
	// fault flags and expansion health
	always @(posedge clk_sys) begin
		if (rst) begin
			base_output_group_fault <= 1'b0;
			exp_fault_outputs_lower <= 1'b0;
			exp_fault_outputs_upper <= 1'b0;
			expansion_down_flag     <= 1'b0;
		end else begin
			base_output_group_fault <= |s_bflt; // RULE_01
			exp_fault_outputs_lower <= exp_used & s_up & s_eflt[0]; // RULE_02 RULE_09
			exp_fault_outputs_upper <= exp_used & s_up & s_eflt[1]; // RULE_02 RULE_09
			expansion_down_flag     <= exp_down; // RULE_03 RULE_10
		end
	end

	// ==============================
	// base input debounce
	reg  [3:0]  deb_stage_r;
	reg  [11:0] deb_cnt_r;

	// expansion inputs bypass this path
	always @(posedge clk_sys) begin
		if (rst) begin
			deb_stage_r  <= 4'h0;
			deb_cnt_r    <= 12'h0;
			base_clean_r <= 4'h0;
		end else if (!deb_en) begin
			base_clean_r <= s_bin; // RULE_06
			deb_stage_r  <= s_bin;
			deb_cnt_r    <= 12'h0;
		end else if (s_bin != deb_stage_r) begin
			deb_stage_r <= s_bin;
			deb_cnt_r   <= 12'h0;
		end else if (deb_cnt_r >= `LD_DEB_MS) begin
			base_clean_r <= deb_stage_r; // RULE_06
		end else if (ms_r) begin
			deb_cnt_r <= deb_cnt_r + 12'h1;
		end
	end

	// ==============================
	// expansion transfer latency
	wire [11:0] in_lat  = exp_rem ? `LD_EXP_IN_REM_MS : `LD_EXP_IN_LOC_MS;
	wire [11:0] out_lat = exp_rem ? `LD_EXP_OUT_REM_MS : `LD_EXP_OUT_LOC_MS;
	reg  [11:0] in_stage_r;
	reg  [11:0] in_tim_r;
	reg  [7:0]  out_stage_r;
	reg  [11:0] out_tim_r;

	// inputs: stable for latency, then taken at next scan
	always @(posedge clk_sys) begin
		if (rst) begin
			in_stage_r               <= 12'h0;
			in_tim_r                 <= 12'h0;
			expansion_input_contacts <= 12'h0;
		end else if (!exp_used || !s_up) begin
			expansion_input_contacts <= 12'h0; // RULE_09
			in_stage_r               <= 12'h0;
			in_tim_r                 <= 12'h0;
		end else if (s_ein != in_stage_r) begin
			in_stage_r <= s_ein; // RULE_04
			in_tim_r   <= 12'h0;
		end else if (in_tim_r >= in_lat) begin
			if (scan_tick) begin
				expansion_input_contacts <= in_stage_r; // RULE_07 RULE_08
			end
		end else if (ms_r) begin
			in_tim_r <= in_tim_r + 12'h1;
		end
	end

	// outputs: held while link is down, sent after latency and scan
	always @(posedge clk_sys) begin
		if (rst) begin
			out_stage_r             <= 8'h0;
			out_tim_r               <= 12'h0;
			expansion_output_relays <= 8'h0;
		end else if (exp_out_r != out_stage_r) begin
			out_stage_r <= exp_out_r;
			out_tim_r   <= 12'h0;
		end else if (out_tim_r >= out_lat) begin
			if (scan_tick && exp_used && s_up) begin
				expansion_output_relays <= out_stage_r; // RULE_04 RULE_07 RULE_08 RULE_11
			end
		end else if (ms_r) begin
			out_tim_r <= out_tim_r + 12'h1;
		end
	end

	// ==============================
	// serial interface inactivity supervision
	reg  [11:0] ser_to;
	reg  [11:0] ser_tim_r;

	// timeout by baud rate
	always @* begin
		case (baud)
			2'h0:    ser_to = `LD_SER_TO_96_MS; // RULE_12
			2'h1:    ser_to = `LD_SER_TO_192_MS;
			2'h2:    ser_to = `LD_SER_TO_384_MS;
			default: ser_to = `LD_SER_TO_576_MS;
		endcase
	end

	// exchange tracking, drop on stall
	always @(posedge clk_sys) begin
		if (rst) begin
			ser_busy_r <= 1'b0;
			ser_tim_r  <= 12'h0;
			ser_drop   <= 1'b0;
		end else begin
			ser_drop <= 1'b0;
			if (ser_rx_start) begin
				ser_busy_r <= 1'b1;
				ser_tim_r  <= 12'h0;
			end else if (ser_busy_r && ser_rx_done) begin
				ser_busy_r <= 1'b0; // RULE_20
				ser_tim_r  <= 12'h0;
			end else if (ser_busy_r && ser_rx_char) begin
				ser_tim_r <= 12'h0; // RULE_20
			end else if (ser_busy_r && ser_tim_r >= ser_to) begin
				ser_busy_r <= 1'b0; // RULE_13
				ser_tim_r  <= 12'h0;
				ser_drop   <= 1'b1;
			end else if (ser_busy_r && ms_r) begin
				ser_tim_r <= ser_tim_r + 12'h1;
			end
		end
	end

	// ==============================
	// peer link supervision
	reg  [11:0] crc_to;
	reg  [11:0] nr_to;
	reg         crc_pend_r;
	reg  [11:0] crc_tim_r;
	reg  [11:0] nr_tim_r;
	wire        crc_exp = crc_pend_r && crc_tim_r >= crc_to;
	wire        nr_exp  = nr_tim_r >= nr_to;
	wire        flt_set = link_en & (crc_exp | nr_exp);

	// peer timeouts by baud, faster rates keep the 19.2 figures
	always @* begin
		case (baud)
			2'h0: begin
				crc_to = `LD_CRC_TO_96_MS; // RULE_15
				nr_to  = `LD_NR_TO_96_MS; // RULE_16
			end
			default: begin
				crc_to = `LD_CRC_TO_192_MS; // RULE_15
				nr_to  = `LD_NR_TO_192_MS; // RULE_16
			end
		endcase
	end

	// timers, fault bit, remote operands, retry
	always @(posedge clk_sys) begin
		if (rst) begin
			crc_pend_r          <= 1'b0;
			crc_tim_r           <= 12'h0;
			nr_tim_r            <= 12'h0;
			peer_link_fault_bit <= 1'b0;
			remote_r            <= 16'h0;
			peer_retry          <= 1'b0;
		end else if (!link_en) begin
			crc_pend_r          <= 1'b0;
			crc_tim_r           <= 12'h0;
			nr_tim_r            <= 12'h0;
			peer_link_fault_bit <= 1'b0; // RULE_14
			peer_retry          <= 1'b0;
		end else begin
			peer_retry <= 1'b0;
			if (flt_set) begin
				peer_link_fault_bit <= 1'b1; // RULE_14 RULE_15 RULE_16
				remote_r            <= 16'h0; // RULE_17
				peer_retry          <= 1'b1; // RULE_18
				crc_pend_r          <= 1'b0;
				crc_tim_r           <= 12'h0;
				nr_tim_r            <= 12'h0;
			end else if (peer_resp) begin
				peer_link_fault_bit <= 1'b0;
				remote_r            <= peer_rd_data;
				crc_pend_r          <= 1'b0;
				crc_tim_r           <= 12'h0;
				nr_tim_r            <= 12'h0;
			end else begin
				if (peer_crc_err) begin
					crc_pend_r <= 1'b1; // RULE_15
				end
				if (crc_pend_r && ms_r) begin
					crc_tim_r <= crc_tim_r + 12'h1;
				end
				if (ms_r) begin
					nr_tim_r <= nr_tim_r + 12'h1; // RULE_16
				end
			end
		end
	end

endmodule

/* File: dv/ld_diag_asserts.sv */
`timescale 1ns/1ps
// ==============================
// port checker
module ld_diag_asserts (
	// clock and reset
	input logic        clk_sys,
	input logic        rst,
	// watched ports
	input logic [3:0]  base_out_flt,
	input logic        exp_link_up,
	input logic        base_output_group_fault,
	input logic        exp_fault_outputs_upper,
	input logic        exp_fault_outputs_lower,
	input logic        expansion_down_flag,
	input logic [11:0] expansion_input_contacts,
	input logic [7:0]  expansion_output_relays,
	input logic        ser_drop,
	input logic        peer_retry,
	input logic        peer_link_fault_bit
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// link state held past the synchronisers
	sequence s_dn; !exp_link_up [*5]; endsequence
	sequence s_up; exp_link_up [*5]; endsequence
	property p_fs; (base_out_flt != 4'h0) [*5] |-> base_output_group_fault; endproperty
	property p_fc; (base_out_flt == 4'h0) [*5] |-> !base_output_group_fault; endproperty
	property p_dz; s_dn |-> !exp_fault_outputs_upper && !exp_fault_outputs_lower
		&& expansion_input_contacts == 12'h000; endproperty
	property p_hold; s_dn |=> $stable(expansion_output_relays); endproperty
	property p_ok; s_up |-> !expansion_down_flag; endproperty
	property p_rf; peer_retry |-> ##[0:1] peer_link_fault_bit; endproperty
	property p_rp; peer_retry |=> !peer_retry; endproperty
	property p_dp; ser_drop |=> !ser_drop; endproperty
	a_fs: assert property (p_fs) else $error("group fault low");
	a_fc: assert property (p_fc) else $error("group fault high");
	a_dz: assert property (p_dz) else $error("link down data");
	a_hold: assert property (p_hold) else $error("relays moved");
	a_ok: assert property (p_ok) else $error("down flag set");
	a_rf: assert property (p_rf) else $error("retry no fault");
	a_rp: assert property (p_rp) else $error("retry long");
	a_dp: assert property (p_dp) else $error("drop long");
endmodule
bind ld_diag ld_diag_asserts u_chk (.*);

/* File: dv/ld_exp_peer.sv */
`timescale 1ns/1ps
// ==============================
// expansion unit and peer station
module ld_exp_peer (
	// clock
	input  logic        clk_sys,
	// bench commands
	input  logic        up,
	input  logic [1:0]  flt,
	input  logic [11:0] din,
	input  logic [7:0]  dly,
	input  logic        go,
	input  logic        bad,
	// link side
	output logic        exp_link_up = 1'h0,
	output logic [1:0]  exp_flt = 2'h0,
	output logic [11:0] exp_in = 12'h000,
	output logic        peer_resp = 1'h0,
	output logic        peer_crc_err = 1'h0,
	output logic [15:0] peer_rd_data = 16'h0000
);
	logic [7:0] cnt_r = 8'h00;
	// released lines toggle, not hold
	always @(posedge clk_sys) begin
		exp_link_up <= up;
		exp_flt     <= up ? flt : ~exp_flt;
		exp_in      <= up ? din : ~exp_in;
	end
	// answer after dly cycles
	always @(posedge clk_sys) begin
		cnt_r        <= go ? dly : cnt_r - (cnt_r != 8'h00);
		peer_resp    <= cnt_r == 8'h01 && !bad;
		peer_crc_err <= cnt_r == 8'h01 && bad;
		peer_rd_data <= (cnt_r == 8'h01) ? 16'h5a3c : ~peer_rd_data;
	end
endmodule

/* File: dv/ld_diag_tb.sv */
`timescale 1ns/1ps
`include "ld_diag_map.vh"
// ==============================
// bench top
module ld_diag_tb;
	localparam int M = 4;
	logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, re;
	logic        scan_tick = 0, ser_rx_start = 0, ser_rx_char = 0, ser_rx_done = 0;
	logic        up = 0, go = 0, bad = 0;
	logic [1:0]  flt = 0;
	logic [2:0]  sc = 0;
	logic [3:0]  base_out_flt = 0, base_in = 0;
	logic [7:0]  paddr = 0, er = 0, dly = 0;
	logic [11:0] din = 0;
	logic [31:0] pwdata = 0, rq;
	int          error_cnt = 0, n_tests = 0, tmo = 0;
	wire         pready, pslverr, exp_link_up, peer_resp, peer_crc_err, ser_drop, peer_retry;
	wire         base_output_group_fault, exp_fault_outputs_upper, exp_fault_outputs_lower;
	wire         expansion_down_flag, peer_link_fault_bit;
	wire [1:0]   exp_flt;
	wire [7:0]   expansion_output_relays;
	wire [11:0]  exp_in, expansion_input_contacts;
	wire [15:0]  peer_rd_data;
	wire [31:0]  prdata;
	ld_diag #(.MS_CYCLES(M)) dut (.*);
	ld_exp_peer u_peer (.*);
	// clock, scan pulses, watchdog
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		sc        <= sc + 3'h1;
		scan_tick <= sc == 3'h7;
		tmo       <= tmo + 1;
		if (tmo == 95000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task chk(input string nm, input logic [63:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task end_of_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cy(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one apb transfer into rq and re
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		cy(1);
		penable <= 1'h1;
		do cy(1); while (pready !== 1'h1);
		rq = prdata;
		re = pslverr;
		{psel, penable} <= 2'h0;
		cy(1);
	endtask
	// cycles until drop or retry
	task wt(input bit s, input int t, input string nm);
		int n;
		n = 0;
		while ((s ? peer_retry : ser_drop) !== 1'h1 && n < (t + 2) * M) begin
			cy(1);
			n++;
		end
		chk(nm, n >= (t - 2) * M && n <= (t + 1) * M + 8, 1'h1);
	endtask
	// peer answers quickly when good, slowly with checksum fault
	task ask(input logic k);
		{bad, dly, go} <= {k, k ? 8'h28 : 8'h01, 1'h1};
		cy(1);
		go <= 1'h0;
		while ((peer_resp | peer_crc_err) !== 1'h1)
			cy(1);
	endtask
	task t_reset;
		apb(0, `LD_OFS_CTRL, 0);
		chk("ctrl", rq, 32'h4);
		apb(0, 8'h3c, 0);
		chk("unmapped", {re, rq}, {1'h1, 32'h0});
	endtask
	task t_base;
		for (int i = 0; i < 4; i++) begin
			base_out_flt <= 4'h1 << i;
			cy(6);
			chk("base_flt", base_output_group_fault, 1'h1);
			base_out_flt <= 4'h0;
			cy(6);
			chk("base_ok", base_output_group_fault, 1'h0);
		end
		base_in <= 4'h9;
		cy(8);
		apb(0, `LD_OFS_BASEIN, 0);
		chk("deb_early", rq, 32'h0);
		cy(24 * M);
		apb(0, `LD_OFS_BASEIN, 0);
		chk("deb_late", rq, 32'h9);
	endtask
	task t_exp(input logic r, input int li, lo, input logic [11:0] v);
		logic [11:0] o;
		o = din;
		apb(1, `LD_OFS_CTRL, {29'h0, 1'h1, r, 1'h1});
		{up, flt} <= 3'h6;
		cy(8);
		chk("flt_up", {exp_fault_outputs_upper, exp_fault_outputs_lower}, 2'h2);
		flt <= 2'h1;
		cy(8);
		chk("flt_lo", {exp_fault_outputs_upper, exp_fault_outputs_lower}, 2'h1);
		din <= v;
		cy((li - 2) * M);
		chk("in_early", expansion_input_contacts, o);
		cy(4 * M + 16);
		chk("in_late", expansion_input_contacts, v);
		apb(1, `LD_OFS_EXPOUT, ~v[7:0]);
		cy((lo - 2) * M);
		chk("out_early", expansion_output_relays, er);
		er = ~v[7:0];
		cy(4 * M + 16);
		chk("out_late", expansion_output_relays, er);
	endtask
	task t_down;
		up <= 1'h0;
		cy(8);
		chk("down", {expansion_down_flag, exp_fault_outputs_upper, exp_fault_outputs_lower}, 3'h4);
		chk("in_zero", expansion_input_contacts, 12'h0);
		apb(0, `LD_OFS_STATUS, 0);
		chk("status", rq, 32'h8);
		apb(1, `LD_OFS_EXPOUT, 32'h81);
		cy(50 * M);
		chk("hold", expansion_output_relays, er);
		apb(1, `LD_OFS_CTRL, 32'h4);
		cy(4);
		chk("unused", expansion_down_flag, 1'h0);
		up <= 1'h1;
		apb(1, `LD_OFS_CTRL, 32'h5);
		cy(20 * M);
		chk("back", {expansion_down_flag, expansion_output_relays}, 9'h081);
	endtask
	task t_ser(input logic [1:0] b, input int t);
		apb(1, `LD_OFS_CTRL, {26'h0, b, 4'h4});
		ser_rx_start <= 1'h1;
		cy(1);
		ser_rx_start <= 1'h0;
		cy(t * M / 4);
		ser_rx_char <= 1'h1;
		cy(1);
		ser_rx_char <= 1'h0;
		wt(0, t, "ser_to");
	endtask
	task t_peer(input logic b, input int tn, tc);
		apb(1, `LD_OFS_CTRL, {26'h0, 1'h0, b, 4'hc});
		ask(0);
		apb(0, `LD_OFS_REMOTE, 0);
		chk("remote", {peer_link_fault_bit, rq}, {1'h0, 32'h5a3c});
		wt(1, tn, "no_resp");
		cy(2);
		apb(0, `LD_OFS_REMOTE, 0);
		chk("cleared", {peer_link_fault_bit, rq}, {1'h1, 32'h0});
		ask(0);
		ask(1);
		wt(1, tc, "crc");
		apb(1, `LD_OFS_CTRL, 32'h4);
		cy(2);
		chk("off", peer_link_fault_bit, 1'h0);
	endtask
	// main sequence
	initial begin
		cy(8);
		rst <= 1'h0;
		t_reset();
		t_base();
		t_exp(0, 30, 15, 12'ha5c);
		t_exp(1, 80, 40, 12'h3c5);
		t_down();
		t_ser(0, 4000);
		t_ser(1, 3200);
		t_ser(2, 2400);
		t_ser(3, 2000);
		t_peer(0, 1500, 250);
		t_peer(1, 800, 120);
		end_of_test();
	end
endmodule
